// File: iwls_status_block.sv
/*
 * Input voltage warning limits, latched status flags and the alert line.
 * Assumes a serial front end that decodes transactions into one-cycle
 * command strobes, and a measurement path that delivers each input
 * voltage code with a one-cycle valid pulse; all inputs synchronous.
 */
`timescale 1ns/100ps

`include "iwls_params.svh"

// Overview of operation
// [R1] input above overvoltage limit sets overvoltage warning flags and alert
// [R2] overvoltage limit thresholds 0..0ffe; 0fff disables check and is reset value
// [R3] input below undervoltage limit sets undervoltage warning flags and alert
// [R4] undervoltage limit thresholds 1..0fff; 0000 disables check and is reset value
// [R5] host accesses both limits with word reads and word writes
// [R6] host scales limits with the telemetry coefficients
// [R7] flags hold until cause is gone and clear-faults arrives
// [R8] status byte bit 6 is one while the pass switch is off
// [R9] status byte bits 3,2,1: input undervoltage, temperature, communication
// [R10] status byte bit 0 flags any fault not covered by bits 7..1
// [R11] status byte read as byte; unsupported byte and word bits read zero
// [R12] status word read as word; low byte equals status byte
// [R13] word bits 15,13,12: output voltage, input, manufacturer faults
// [R14] word bit 11 set once power good has been negated
// [R15] output voltage status read as byte; only bit 5 implemented
// [R16] input status read as byte; latched like other status registers
// [R17] clear-faults resets flags and alert; live causes set again at once
// [R18] input status bit 6 overvoltage warning, bit 5 undervoltage warning
// [R19] each new measurement is compared and flags set in that cycle
module iwls_status_block #(
    parameter int VIN_W = 16
)(
    input wire logic I_MCLK,
    input wire logic I_NRST,
    input wire iwls_pkg::iwls_cmd_s I_CMD,
    input wire logic I_VIN_VALID,
    input wire logic [VIN_W-1:0] I_VIN_CODE,
    input wire iwls_pkg::iwls_cond_s I_COND,
    output logic O_SMBALERT_N,
    output iwls_pkg::iwls_rsp_s O_RSP
);
    import iwls_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] ov_limit;
        logic [15:0] uv_limit;
        logic        ov_cond;
        logic        uv_cond;
        iwls_flags_s flags;
        logic        alert_n;
        iwls_rsp_s   rsp;
    } iwls_state_s;

    iwls_state_s cur_ff;
    iwls_state_s nxt_ff;

    logic [15:0] vin_code;
    logic clr;
    logic ov_hit;
    logic uv_hit;
    logic ov_live;
    logic uv_live;
    logic [7:0] status_byte;
    logic [15:0] status_word;
    logic [7:0] output_voltage_status;
    logic [7:0] status_input;
    logic other;
    logic input_any;

    assign vin_code = 16'(I_VIN_CODE);

    // ------------------------------------------------------------------
    // limit comparison
    // ------------------------------------------------------------------
    always_comb
    begin
        ov_hit = (cur_ff.ov_limit != `IWLS_OV_LIMIT_OFF) && (vin_code > cur_ff.ov_limit); // R1 R2
        uv_hit = (cur_ff.uv_limit != `IWLS_UV_LIMIT_OFF) && (vin_code < cur_ff.uv_limit); // R3 R4
        // a fresh sample is judged in its own cycle, else the last verdict holds
        ov_live = I_VIN_VALID ? ov_hit : cur_ff.ov_cond; // R19
        uv_live = I_VIN_VALID ? uv_hit : cur_ff.uv_cond; // R19
    end

    // ------------------------------------------------------------------
    // status views
    // ------------------------------------------------------------------
    always_comb
    begin
        other = cur_ff.flags.vin_ov_warn | cur_ff.flags.vin_uv_warn
              | cur_ff.flags.vin_ov_fault | cur_ff.flags.iin_oc_fault
              | cur_ff.flags.iin_oc_warn | cur_ff.flags.pin_op_warn
              | cur_ff.flags.vout_uv_warn | cur_ff.flags.mfr
              | cur_ff.flags.pgood_lost; // R10
        input_any = cur_ff.flags.vin_ov_warn | cur_ff.flags.vin_uv_warn
                  | cur_ff.flags.vin_ov_fault | cur_ff.flags.vin_uv_fault
                  | cur_ff.flags.iin_oc_fault | cur_ff.flags.iin_oc_warn
                  | cur_ff.flags.pin_op_warn;

        // unsupported bits stay zero
        status_byte = 8'h00; // R11
        status_byte[`IWLS_SB_OFF] = ~I_COND.switch_on; // R8
        status_byte[`IWLS_SB_VIN_UV] = cur_ff.flags.vin_uv_fault; // R9
        status_byte[`IWLS_SB_TEMP] = cur_ff.flags.temp; // R9
        status_byte[`IWLS_SB_CML] = cur_ff.flags.cml; // R9
        status_byte[`IWLS_SB_OTHER] = other; // R10

        status_word = {8'h00, status_byte}; // R12 R11
        status_word[`IWLS_SW_VOUT] = cur_ff.flags.vout_uv_warn; // R13
        status_word[`IWLS_SW_INPUT] = input_any; // R13
        status_word[`IWLS_SW_MFR] = cur_ff.flags.mfr; // R13
        status_word[`IWLS_SW_PGOOD_N] = cur_ff.flags.pgood_lost; // R14

        output_voltage_status = 8'h00; // R15
        output_voltage_status[`IWLS_SV_VOUT_UV_WARN] = cur_ff.flags.vout_uv_warn; // R15

        status_input = 8'h00;
        status_input[`IWLS_SI_VIN_OV_FAULT] = cur_ff.flags.vin_ov_fault; // R16
        status_input[`IWLS_SI_VIN_OV_WARN] = cur_ff.flags.vin_ov_warn; // R18
        status_input[`IWLS_SI_VIN_UV_WARN] = cur_ff.flags.vin_uv_warn; // R18
        status_input[`IWLS_SI_VIN_UV_FAULT] = cur_ff.flags.vin_uv_fault; // R16
        status_input[`IWLS_SI_IIN_OC_FAULT] = cur_ff.flags.iin_oc_fault; // R16
        status_input[`IWLS_SI_IIN_OC_WARN] = cur_ff.flags.iin_oc_warn; // R16
        status_input[`IWLS_SI_PIN_OP_WARN] = cur_ff.flags.pin_op_warn; // R16
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_ff = cur_ff;
        clr = I_CMD.valid && I_CMD.write && (I_CMD.code == `IWLS_CMD_CLEAR_FAULTS);

        nxt_ff.ov_cond = ov_live;
        nxt_ff.uv_cond = uv_live;

        // limit writes; word reads return them whole
        if (I_CMD.valid && I_CMD.write && I_CMD.code == `IWLS_CMD_VIN_OV_LIMIT)
        begin
            nxt_ff.ov_limit = I_CMD.wdata; // R2
        end
        if (I_CMD.valid && I_CMD.write && I_CMD.code == `IWLS_CMD_VIN_UV_LIMIT)
        begin
            nxt_ff.uv_limit = I_CMD.wdata; // R4
        end

        // clear first, then a present cause sets again: set wins
        if (clr)
        begin
            nxt_ff.flags = '0; // R17
        end
        nxt_ff.flags.vin_ov_warn = nxt_ff.flags.vin_ov_warn | ov_live; // R1 R7
        nxt_ff.flags.vin_uv_warn = nxt_ff.flags.vin_uv_warn | uv_live; // R3 R7
        nxt_ff.flags.vin_ov_fault = nxt_ff.flags.vin_ov_fault | I_COND.vin_ov_fault; // R7
        nxt_ff.flags.vin_uv_fault = nxt_ff.flags.vin_uv_fault | I_COND.vin_uv_fault; // R7
        nxt_ff.flags.iin_oc_fault = nxt_ff.flags.iin_oc_fault | I_COND.iin_oc_fault; // R7
        nxt_ff.flags.iin_oc_warn = nxt_ff.flags.iin_oc_warn | I_COND.iin_oc_warn; // R7
        nxt_ff.flags.pin_op_warn = nxt_ff.flags.pin_op_warn | I_COND.pin_op_warn; // R7
        nxt_ff.flags.temp = nxt_ff.flags.temp | I_COND.temp; // R7
        nxt_ff.flags.cml = nxt_ff.flags.cml | I_COND.cml; // R7
        nxt_ff.flags.vout_uv_warn = nxt_ff.flags.vout_uv_warn | I_COND.vout_uv_warn; // R7
        nxt_ff.flags.mfr = nxt_ff.flags.mfr | I_COND.mfr; // R7
        nxt_ff.flags.pgood_lost = nxt_ff.flags.pgood_lost | ~I_COND.pgood; // R14 R7

        nxt_ff.alert_n = ~(|nxt_ff.flags); // R1 R3 R17

        // read answers one cycle after the request; unknown codes give zero
        nxt_ff.rsp.valid = I_CMD.valid && !I_CMD.write;
        nxt_ff.rsp.rdata = 16'h0000;
        if (I_CMD.valid && !I_CMD.write)
        begin
            case (I_CMD.code)
                `IWLS_CMD_VIN_OV_LIMIT: nxt_ff.rsp.rdata = cur_ff.ov_limit; // R5
                `IWLS_CMD_VIN_UV_LIMIT: nxt_ff.rsp.rdata = cur_ff.uv_limit; // R5
                `IWLS_CMD_STATUS_BYTE: nxt_ff.rsp.rdata = {8'h00, status_byte}; // R11
                `IWLS_CMD_STATUS_WORD: nxt_ff.rsp.rdata = status_word; // R12
                `IWLS_CMD_OUTPUT_VOLTAGE_STATUS: nxt_ff.rsp.rdata = {8'h00, output_voltage_status}; // R15
                `IWLS_CMD_STATUS_INPUT: nxt_ff.rsp.rdata = {8'h00, status_input}; // R16
                default: nxt_ff.rsp.rdata = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            cur_ff <= '0;
            cur_ff.ov_limit <= `IWLS_OV_LIMIT_RST; // R2
            cur_ff.uv_limit <= `IWLS_UV_LIMIT_RST; // R4
            cur_ff.alert_n <= 1'b1;
        end
        else
        begin
            cur_ff <= nxt_ff;
        end
    end

    assign O_SMBALERT_N = cur_ff.alert_n;
    assign O_RSP = cur_ff.rsp;

endmodule

// File: iwls_params.svh
/*
 * Constants of the input warning limit and status block: command codes,
 * reset values and bit positions of the status registers.
 * Assumes inclusion by the block, the checker and the bench only.
 */
`ifndef IWLS_PARAMS_SVH
`define IWLS_PARAMS_SVH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define IWLS_CMD_CLEAR_FAULTS    8'h03
`define IWLS_CMD_VIN_OV_LIMIT    8'h57
`define IWLS_CMD_VIN_UV_LIMIT    8'h58
`define IWLS_CMD_STATUS_BYTE     8'h78
`define IWLS_CMD_STATUS_WORD     8'h79
`define IWLS_CMD_OUTPUT_VOLTAGE_STATUS     8'h7a
`define IWLS_CMD_STATUS_INPUT    8'h7c

// ----------------------------------------------------------------------
// limit reset values and disable codes
// ----------------------------------------------------------------------
`define IWLS_OV_LIMIT_RST        16'h0fff
`define IWLS_OV_LIMIT_OFF        16'h0fff
`define IWLS_UV_LIMIT_RST        16'h0000
`define IWLS_UV_LIMIT_OFF        16'h0000

// ----------------------------------------------------------------------
// status byte and word bit positions
// ----------------------------------------------------------------------
`define IWLS_SB_OFF              6
`define IWLS_SB_VIN_UV           3
`define IWLS_SB_TEMP             2
`define IWLS_SB_CML              1
`define IWLS_SB_OTHER            0
`define IWLS_SW_VOUT             15
`define IWLS_SW_INPUT            13
`define IWLS_SW_MFR              12
`define IWLS_SW_PGOOD_N          11

// ----------------------------------------------------------------------
// output voltage and input status bit positions
// ----------------------------------------------------------------------
`define IWLS_SV_VOUT_UV_WARN     5
`define IWLS_SI_VIN_OV_FAULT     7
`define IWLS_SI_VIN_OV_WARN      6
`define IWLS_SI_VIN_UV_WARN      5
`define IWLS_SI_VIN_UV_FAULT     4
`define IWLS_SI_IIN_OC_FAULT     2
`define IWLS_SI_IIN_OC_WARN      1
`define IWLS_SI_PIN_OP_WARN      0

`endif

// File: iwls_pkg.sv
/*
 * Types of the input warning limit and status block.
 * Assumes iwls_params.svh is reachable by bare name.
 */
package iwls_pkg;

    // ------------------------------------------------------------------
    // command port from the serial front end
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] wdata;
    } iwls_cmd_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] rdata;
    } iwls_rsp_s;

    // ------------------------------------------------------------------
    // fault and warning conditions from the rest of the device
    // ------------------------------------------------------------------
    typedef struct packed {
        logic switch_on;
        logic pgood;
        logic vin_ov_fault;
        logic vin_uv_fault;
        logic iin_oc_fault;
        logic iin_oc_warn;
        logic pin_op_warn;
        logic temp;
        logic cml;
        logic vout_uv_warn;
        logic mfr;
    } iwls_cond_s;

    // ------------------------------------------------------------------
    // latched flags
    // ------------------------------------------------------------------
    typedef struct packed {
        logic vin_ov_warn;
        logic vin_uv_warn;
        logic vin_ov_fault;
        logic vin_uv_fault;
        logic iin_oc_fault;
        logic iin_oc_warn;
        logic pin_op_warn;
        logic temp;
        logic cml;
        logic vout_uv_warn;
        logic mfr;
        logic pgood_lost;
    } iwls_flags_s;

endpackage

// File: iwls_status_monitor.sv
/*
 * Port checker of the status block.
 * Assumes one clock and the bind at the foot of this file.
 */
`timescale 1ns/100ps
`include "iwls_params.svh"
module iwls_status_monitor #(
    parameter int VIN_W = 16
)(
    input wire logic I_MCLK,
    input wire logic I_NRST,
    input wire iwls_pkg::iwls_cmd_s I_CMD,
    input wire logic I_VIN_VALID,
    input wire logic [VIN_W-1:0] I_VIN_CODE,
    input wire iwls_pkg::iwls_cond_s I_COND,
    input wire logic O_SMBALERT_N,
    input wire iwls_pkg::iwls_rsp_s O_RSP
);
    import iwls_pkg::*;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_NRST);
    sequence s_rd(c);
        I_CMD.valid && !I_CMD.write && I_CMD.code == c;
    endsequence
    property p_rsp;
        I_CMD.valid && !I_CMD.write |=> O_RSP.valid;
    endproperty
    property p_norsp;
        !(I_CMD.valid && !I_CMD.write) |=> !O_RSP.valid;
    endproperty
    property p_idle;
        !O_RSP.valid |-> O_RSP.rdata == 16'h0000;
    endproperty
    property p_byte;
        s_rd(`IWLS_CMD_STATUS_BYTE) |=> (O_RSP.rdata & 16'hffb0) == 16'h0000;
    endproperty
    property p_word;
        s_rd(`IWLS_CMD_STATUS_WORD) |=> (O_RSP.rdata & 16'h47b0) == 16'h0000;
    endproperty
    property p_vout;
        s_rd(`IWLS_CMD_OUTPUT_VOLTAGE_STATUS) |=> (O_RSP.rdata & 16'hffdf) == 16'h0000;
    endproperty
    property p_off;
        s_rd(`IWLS_CMD_STATUS_BYTE) ##0 !I_COND.switch_on ##1 !I_COND.switch_on
            |-> O_RSP.rdata[6];
    endproperty
    property p_hold;
        !O_SMBALERT_N
            && !(I_CMD.valid && I_CMD.write && I_CMD.code == `IWLS_CMD_CLEAR_FAULTS)
            |=> !O_SMBALERT_N;
    endproperty
    property p_cause;
        I_COND.temp || I_COND.cml || I_COND.mfr |=> !O_SMBALERT_N;
    endproperty
    a_rsp: assert property (p_rsp) else $error("read not answered");
    a_norsp: assert property (p_norsp) else $error("answer without read");
    a_idle: assert property (p_idle) else $error("data without answer");
    a_byte: assert property (p_byte) else $error("status byte bits");
    a_word: assert property (p_word) else $error("status word bits");
    a_vout: assert property (p_vout) else $error("vout status bits");
    a_off: assert property (p_off) else $error("off bit low");
    a_hold: assert property (p_hold) else $error("alert dropped");
    a_cause: assert property (p_cause) else $error("alert missing");
endmodule

bind iwls_status_block iwls_status_monitor #(.VIN_W(VIN_W)) i_mon (
    .I_MCLK(I_MCLK), .I_NRST(I_NRST), .I_CMD(I_CMD), .I_VIN_VALID(I_VIN_VALID),
    .I_VIN_CODE(I_VIN_CODE), .I_COND(I_COND), .O_SMBALERT_N(O_SMBALERT_N),
    .O_RSP(O_RSP));

// File: iwls_host_model.sv
/*
 * Management host model: issues one command at a time.
 * Assumes the block answers reads one cycle after taking them.
 */
`timescale 1ns/100ps
module iwls_host_model (
    input wire logic i_clk,
    input wire iwls_pkg::iwls_rsp_s i_rsp,
    output iwls_pkg::iwls_cmd_s o_cmd
);
    import iwls_pkg::*;
    initial o_cmd = '0;
    // limits go as whole words; idle fields change so stale data is not seen
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] rd);
        @(posedge i_clk);
        #1 o_cmd = {1'b1, w, c, d};
        @(posedge i_clk);
        #1 rd = i_rsp.valid ? i_rsp.rdata : 16'hxxxx;
        o_cmd = {1'b0, ~o_cmd[24:0]};
    endtask
endmodule

// File: tb.sv
/*
 * Self-checking bench of the status block.
 * Assumes the host model and checker files are compiled first.
 */
`timescale 1ns/100ps
`include "iwls_params.svh"
module tb;
    import iwls_pkg::*;
    logic I_MCLK = 1'b0;
    logic I_NRST = 1'b0;
    logic I_VIN_VALID = 1'b0;
    logic [15:0] I_VIN_CODE = 16'h0000;
    iwls_cond_s I_COND = 11'h600;
    iwls_cmd_s I_CMD;
    iwls_rsp_s O_RSP;
    logic O_SMBALERT_N;
    int n_mismatch = 0;
    int checked = 0;
    logic [15:0] r;
    logic [15:0] lim;
    logic [15:0] wt [11] = '{16'h1001, 16'h8001, 16'h0002, 16'h0004, 16'h2001,
        16'h2001, 16'h2001, 16'h2008, 16'h2001, 16'h0801, 16'h0040};
    logic [7:0] it [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h04,
        8'h10, 8'h80, 8'h00, 8'h00};
    always #5 I_MCLK = ~I_MCLK;
    iwls_status_block #(.VIN_W(16)) i_iwls_status_block (.I_MCLK(I_MCLK),
        .I_NRST(I_NRST), .I_CMD(I_CMD), .I_VIN_VALID(I_VIN_VALID),
        .I_VIN_CODE(I_VIN_CODE), .I_COND(I_COND), .O_SMBALERT_N(O_SMBALERT_N),
        .O_RSP(O_RSP));
    iwls_host_model i_iwls_host_model (.i_clk(I_MCLK), .i_rsp(O_RSP), .o_cmd(I_CMD));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        i_iwls_host_model.xfer(1'b0, c, 16'h0000, r);
        chk($sformatf("read %h", c), e, r);
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        i_iwls_host_model.xfer(1'b1, c, d, r);
    endtask
    task automatic al(input logic e);
        chk("alert", {15'h0000, e}, {15'h0000, O_SMBALERT_N});
    endtask
    // expected warning verdicts: strict compares, disable codes switch the check off
    function automatic logic ov_exp(input logic [15:0] c, input logic [15:0] l);
        return (l != `IWLS_OV_LIMIT_OFF) && (c > l);
    endfunction
    function automatic logic uv_exp(input logic [15:0] c, input logic [15:0] l);
        return (l != `IWLS_UV_LIMIT_OFF) && (c < l);
    endfunction
    task automatic vin(input logic [15:0] c);
        @(posedge I_MCLK);
        #1 I_VIN_VALID = 1'b1;
        I_VIN_CODE = c;
        @(posedge I_MCLK);
        #1 I_VIN_VALID = 1'b0;
        I_VIN_CODE = ~c;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (5000) @(posedge I_MCLK);
        n_mismatch++;
        tally_and_finish();
    end
    initial
    begin
        void'($urandom(17));
        repeat (12) @(posedge I_MCLK);
        #1 I_NRST = 1'b1;
        rd(`IWLS_CMD_VIN_OV_LIMIT, 16'h0fff);
        rd(`IWLS_CMD_VIN_UV_LIMIT, 16'h0000);
        rd(`IWLS_CMD_STATUS_WORD, 16'h0000);
        rd(8'h00, 16'h0000);
        al(1'b1);
        $display("test reset done");
        repeat (4)
        begin
            lim = 16'($urandom);
            wr(`IWLS_CMD_VIN_OV_LIMIT, lim);
            rd(`IWLS_CMD_VIN_OV_LIMIT, lim);
            lim = 16'($urandom);
            wr(`IWLS_CMD_VIN_UV_LIMIT, lim);
            rd(`IWLS_CMD_VIN_UV_LIMIT, lim);
        end
        $display("test limits done");
        wr(`IWLS_CMD_VIN_UV_LIMIT, 16'h0000);
        lim = 16'h0001 + 16'($urandom % 16'h0ffe);
        wr(`IWLS_CMD_VIN_OV_LIMIT, lim);
        vin(lim);
        al(!ov_exp(lim, lim));
        vin(lim + 16'h0001);
        al(!ov_exp(lim + 16'h0001, lim));
        rd(`IWLS_CMD_STATUS_INPUT, 16'h0040);
        rd(`IWLS_CMD_STATUS_WORD, 16'h2001);
        vin(16'h0000);
        rd(`IWLS_CMD_STATUS_INPUT, 16'h0040);
        wr(`IWLS_CMD_CLEAR_FAULTS, 16'h0000);
        al(1'b1);
        wr(`IWLS_CMD_VIN_OV_LIMIT, 16'h0fff);
        vin(16'hffff);
        al(!ov_exp(16'hffff, `IWLS_OV_LIMIT_OFF));
        lim = 16'h0001 + 16'($urandom % 16'h0fff);
        wr(`IWLS_CMD_VIN_UV_LIMIT, lim);
        vin(lim);
        al(!uv_exp(lim, lim));
        vin(lim - 16'h0001);
        rd(`IWLS_CMD_STATUS_INPUT, {10'h000, uv_exp(lim - 16'h0001, lim), 5'h00});
        wr(`IWLS_CMD_CLEAR_FAULTS, 16'h0000);
        rd(`IWLS_CMD_STATUS_INPUT, 16'h0020);
        vin(lim);
        wr(`IWLS_CMD_CLEAR_FAULTS, 16'h0000);
        rd(`IWLS_CMD_STATUS_INPUT, 16'h0000);
        al(1'b1);
        $display("test thresholds done");
        for (int i = 0; i < 11; i++)
        begin
            I_COND = 11'h600 ^ (11'h001 << i);
            rd(`IWLS_CMD_STATUS_BYTE, {8'h00, wt[i][7:0]});
            rd(`IWLS_CMD_STATUS_WORD, wt[i]);
            rd(`IWLS_CMD_STATUS_INPUT, {8'h00, it[i]});
            rd(`IWLS_CMD_OUTPUT_VOLTAGE_STATUS, (i == 1) ? 16'h0020 : 16'h0000);
            al(i == 10);
            I_COND = 11'h600;
            rd(`IWLS_CMD_STATUS_WORD, wt[i] & 16'hffbf);
            wr(`IWLS_CMD_CLEAR_FAULTS, 16'h0000);
            rd(`IWLS_CMD_STATUS_WORD, 16'h0000);
        end
        $display("test conditions done");
        tally_and_finish();
    end
endmodule
